// [ppp_port.sv]
// apb parallel printer port, device side
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
module ppp_port
  import ppp_pkg::*;
#(
  parameter int INIT_CYC = INIT_CYC_DEF
) (
  input  wire logic          mclk,
  input  wire logic          resetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  input  wire ppp_pins_in_t  pins_i,
  output ppp_pins_out_t      pins_o,
  output logic               irq7,
  output logic               irq
);

  logic                rst_q1;
  logic                rst_n;
  ppp_pins_in_t        sync1;
  ppp_pins_in_t        sync2;
  ppp_pins_in_t        sync3;
  logic                ack_evt;
  logic [3:0]          ev;
  logic [7:0]          data_reg;
  logic [4:0]          ctrl;
  logic                int_flag;
  logic [3:0]          ev_st;
  logic [3:0]          ev_en;
  logic [31:0]         init_cnt;
  logic                setup;
  logic                access;
  logic                wr_acc;
  logic                stat_rd;
  logic                mapped;
  logic [7:0]          stat_val;
  logic [31:0]         next_prdata;
  logic [3:0]          next_ev_st;

  // reset release through two flops
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // status input synchronisers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= PINS_IN_IDLE;
      sync2 <= PINS_IN_IDLE;
      sync3 <= PINS_IN_IDLE;
    end else begin
      sync1 <= pins_i;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // edge events from synchronised inputs
  assign ack_evt = sync3.ack_n & ~sync2.ack_n;
  assign ev[EV_ACK]   = ack_evt;
  assign ev[EV_READY] = sync3.busy & ~sync2.busy;
  assign ev[EV_PAPER] = ~sync3.paper_end & sync2.paper_end;
  assign ev[EV_FAULT] = sync3.fault_n & ~sync2.fault_n;

  // apb phase decode
  assign setup   = psel & ~penable;
  assign access  = psel & penable & pready;
  assign wr_acc  = access & pwrite;
  assign stat_rd = access & ~pwrite & (paddr == ADR_STAT);

  always_comb begin
    unique case (paddr)
      ADR_DATA, ADR_STAT, ADR_CTRL,
      ADR_EVST, ADR_EVCLR, ADR_EVEN: mapped = 1'b1;
      default:                       mapped = 1'b0;
    endcase
  end

  // status view
  always_comb begin
    stat_val            = 8'h00;
    stat_val[STA_BUSYN] = ~sync2.busy;
    stat_val[STA_ACK]   = sync2.ack_n;
    stat_val[STA_PE]    = sync2.paper_end;
    stat_val[STA_SEL]   = sync2.selected;
    stat_val[STA_ERR]   = sync2.fault_n;
    stat_val[STA_INT]   = int_flag;
  end

  // read mux
  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      ADR_DATA: next_prdata = {24'h00_0000, data_reg};
      ADR_STAT: next_prdata = {24'h00_0000, stat_val};
      ADR_CTRL: next_prdata = {27'h000_0000, ctrl};
      ADR_EVST: next_prdata = {28'h000_0000, ev_st};
      ADR_EVEN: next_prdata = {28'h000_0000, ev_en};
      default:  next_prdata = 32'h0000_0000;
    endcase
  end

  // apb answer, one wait-free access cycle after setup
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  // data register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      data_reg <= 8'h00;
    end else if (wr_acc && paddr == ADR_DATA) begin
      data_reg <= pwdata[7:0];
    end
  end

  // control register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
    end else if (wr_acc && paddr == ADR_CTRL) begin
      ctrl <= pwdata[4:0];
    end
  end

  // interrupt status bit, set wins over read clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_flag <= 1'b0;
    end else begin
      int_flag <= (ack_evt & ctrl[CTL_IRQEN]) | (int_flag & ~stat_rd);
    end
  end

  // event sticky bits, set wins over clear
  always_comb begin
    next_ev_st = ev_st;
    if (wr_acc && paddr == ADR_EVCLR) begin
      next_ev_st = ev_st & ~pwdata[3:0];
    end
    next_ev_st = next_ev_st | ev;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ev_st <= 4'h0;
      ev_en <= 4'h0;
    end else begin
      ev_st <= next_ev_st;
      if (wr_acc && paddr == ADR_EVEN) begin
        ev_en <= pwdata[3:0];
      end
    end
  end

  // restart pulse stretch
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      init_cnt <= 32'h0000_0000;
    end else if (!ctrl[CTL_INIT]) begin
      init_cnt <= 32'(INIT_CYC);
    end else if (init_cnt != 32'h0000_0000) begin
      init_cnt <= init_cnt - 32'h0000_0001;
    end
  end

  // pin outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pins_o.data     <= 8'h00;
      pins_o.strobe_n <= 1'b1;
      pins_o.autofd_n <= 1'b1;
      pins_o.init_n   <= 1'b1;
      pins_o.selin_n  <= 1'b1;
    end else begin
      pins_o.data     <= data_reg;
      pins_o.strobe_n <= ~ctrl[CTL_STROBE];
      pins_o.autofd_n <= ~ctrl[CTL_AUTOFD];
      pins_o.init_n   <= ctrl[CTL_INIT] & (init_cnt == 32'h0000_0000);
      pins_o.selin_n  <= ~ctrl[CTL_SELIN];
    end
  end

  // interrupt outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq7 <= 1'b0;
      irq  <= 1'b0;
    end else begin
      irq7 <= ctrl[CTL_IRQEN] & int_flag;
      irq  <= |(ev_st & ev_en);
    end
  end

  // helper: cycles the restart pin has been low
  logic [31:0] low_cnt;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt <= 32'h0000_0000;
    end else if (!pins_o.init_n) begin
      low_cnt <= low_cnt + 32'h0000_0001;
    end else begin
      low_cnt <= 32'h0000_0000;
    end
  end

  a_strobe_follow: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $rose(ctrl[CTL_STROBE]) |=> !pins_o.strobe_n ##1 1'b1)
    else $error("strobe pin did not go low after control bit set");

  a_data_pins: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $changed(data_reg) |=> pins_o.data == $past(data_reg))
    else $error("data pins do not follow the data register");

  a_init_width: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $rose(pins_o.init_n) |-> low_cnt > INIT_CYC)
    else $error("restart low pulse too short");

  a_init_release: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ctrl[CTL_INIT] && init_cnt == 32'h0000_0000 |=> pins_o.init_n)
    else $error("restart pin not high when idle");

  a_irq_gate: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !ctrl[CTL_IRQEN] |=> !irq7)
    else $error("interrupt 7 raised while disabled");

  a_ack_to_irq: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ack_evt && ctrl[CTL_IRQEN] ##1 ctrl[CTL_IRQEN] |=> irq7)
    else $error("byte-taken pulse did not raise interrupt 7");

  a_int_set: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ack_evt && ctrl[CTL_IRQEN] |=> int_flag)
    else $error("byte-taken did not set status bit 2");

  a_int_clear: assert property (
    @(posedge mclk) disable iff (!rst_n)
    stat_rd && !ack_evt |=> !int_flag)
    else $error("status read did not clear bit 2");

  a_busy_inverse: assert property (
    @(posedge mclk) disable iff (!rst_n)
    stat_rd |-> prdata[STA_BUSYN] == !$past(sync2.busy))
    else $error("status bit 7 is not the inverse of the busy pin");

  a_autofd_pin: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ctrl[CTL_AUTOFD] |=> !pins_o.autofd_n)
    else $error("line-advance pin not low for set bit");

  a_select_pin: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !ctrl[CTL_SELIN] |=> pins_o.selin_n)
    else $error("choose pin not high for clear bit");

  a_ctrl_read: assert property (
    @(posedge mclk) disable iff (!rst_n)
    access && !pwrite && paddr == ADR_CTRL |-> prdata[4:0] == $past(ctrl))
    else $error("control read does not return stored bits");

  a_sync_depth: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ack_evt |-> !$past(pins_i.ack_n, 2) && $past(pins_i.ack_n, 3))
    else $error("byte-taken event not two stages behind the pin");

  a_strobe_release: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !ctrl[CTL_STROBE] |=> pins_o.strobe_n)
    else $error("strobe pin not high for clear bit");

  a_choose_low: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ctrl[CTL_SELIN] |=> !pins_o.selin_n)
    else $error("choose pin not low for set bit");

  a_autofd_idle: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !ctrl[CTL_AUTOFD] |=> pins_o.autofd_n)
    else $error("line-advance pin not high for clear bit");

endmodule : ppp_port

// [ppp_pkg.sv]
// constants and types for the parallel printer port
// Overview of operation
// - a byte goes to the printer by pulsing the active-low strobe output
// - system reset drives the strobe output high, inactive
// - eight parallel data output lines carry the byte
// - byte-taken pulse raises printer interrupt request 7
// - line-advance output low makes the printer feed one line after printing
// - restart output stays high and pulses low to reset the printer
// - any restart low pulse lasts longer than 50 us
// - choose output low lets the printer accept data, high blocks it
// - with interrupts on, byte-taken sets status bit 2; status read clears it
// - strobe, line-advance, choose pins are inverted control bits; reads give bits
// - control bit 4 gates interrupt request 7
// - status bit 7 reads 1 while the not-accepting pin is low
package ppp_pkg;

  // register word indices; byte address is four times the index
  localparam logic [9:0]  IDX_DATA   = 10'h378;
  localparam logic [9:0]  IDX_STAT   = 10'h379;
  localparam logic [9:0]  IDX_CTRL   = 10'h37A;
  localparam logic [9:0]  IDX_EVST   = 10'h37B;
  localparam logic [9:0]  IDX_EVCLR  = 10'h37C;
  localparam logic [9:0]  IDX_EVEN   = 10'h37D;
  localparam logic [11:0] ADR_DATA   = {IDX_DATA, 2'b00};
  localparam logic [11:0] ADR_STAT   = {IDX_STAT, 2'b00};
  localparam logic [11:0] ADR_CTRL   = {IDX_CTRL, 2'b00};
  localparam logic [11:0] ADR_EVST   = {IDX_EVST, 2'b00};
  localparam logic [11:0] ADR_EVCLR  = {IDX_EVCLR, 2'b00};
  localparam logic [11:0] ADR_EVEN   = {IDX_EVEN, 2'b00};

  // control register fields
  localparam int CTL_STROBE = 0;
  localparam int CTL_AUTOFD = 1;
  localparam int CTL_INIT   = 2;
  localparam int CTL_SELIN  = 3;
  localparam int CTL_IRQEN  = 4;
  localparam logic [4:0] CTRL_RESET = 5'h04;

  // status register fields
  localparam int STA_BUSYN = 7;
  localparam int STA_ACK   = 6;
  localparam int STA_PE    = 5;
  localparam int STA_SEL   = 4;
  localparam int STA_ERR   = 3;
  localparam int STA_INT   = 2;

  // idle levels of the status inputs, used as synchroniser reset
  localparam logic [4:0] PINS_IN_IDLE = 5'h13;

  // event register fields
  localparam int EV_ACK   = 0;
  localparam int EV_READY = 1;
  localparam int EV_PAPER = 2;
  localparam int EV_FAULT = 3;

  // timing
  localparam int CLK_PS       = 4000;
  localparam int INIT_MIN_PS  = 50000000;
  localparam int INIT_CYC_DEF = (INIT_MIN_PS + CLK_PS - 1) / CLK_PS;

  typedef struct packed {
    logic [7:0] data;
    logic       strobe_n;
    logic       autofd_n;
    logic       init_n;
    logic       selin_n;
  } ppp_pins_out_t;

  // input vector bit order: ack_n, busy, paper_end, selected, fault_n
  typedef struct packed {
    logic ack_n;
    logic busy;
    logic paper_end;
    logic selected;
    logic fault_n;
  } ppp_pins_in_t;

endpackage : ppp_pkg

// [ppp_printer.sv]
// behavioural printer model for the parallel port
`timescale 1ns/1ns
module ppp_printer
  import ppp_pkg::*;
#(
  parameter int ACK_CYC = 1250
) (
  input  wire logic          mclk,
  input  wire ppp_pins_out_t pins_o,
  input  wire logic          paper_out,
  input  wire logic          online,
  output ppp_pins_in_t       pins_i,
  output logic [7:0]         got
);
  logic ack_n;
  logic busy_act;
  // not accepting while taking a byte or off-line
  assign pins_i = {ack_n, busy_act | ~online,
                   paper_out,
                   online,
                   ~(paper_out | ~online)};
  initial begin
    ack_n = 1'b1;
    busy_act = 1'b0;
    got = 8'h00;
    forever begin
      @(negedge pins_o.strobe_n);
      got = pins_o.data;
      busy_act = 1'b1;
      @(posedge pins_o.strobe_n);
      repeat (4) @(posedge mclk);
      ack_n <= 1'b0;
      repeat (ACK_CYC) @(posedge mclk);
      ack_n <= 1'b1;
      busy_act <= 1'b0;
    end
  end
endmodule : ppp_printer

// [tb_ppp_port.sv]
// self-checking bench for the parallel printer port
`timescale 1ns/1ns
module tb_ppp_port;
  import ppp_pkg::*;
  localparam int INIT = 20;
  logic          mclk = 1'b0;
  logic          resetn = 1'b0;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [11:0]   paddr = 12'h000;
  logic [31:0]   pwdata = 32'h0;
  logic          pready;
  logic [31:0]   prdata;
  logic          pslverr;
  logic          irq7;
  logic          irq;
  logic          paper_out = 1'b0;
  logic          online = 1'b1;
  logic          err;
  logic [7:0]    got;
  ppp_pins_in_t  pins_i;
  ppp_pins_out_t pins_o;
  int            fails = 0;
  int            checks_done = 0;
  int            cyc = 0;
  int            lowrun = 0;
  int            lastrun = 0;

  always #2 mclk = ~mclk;

  ppp_port #(.INIT_CYC(INIT)) i_ppp_port (.mclk(mclk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pins_i(pins_i), .pins_o(pins_o), .irq7(irq7), .irq(irq));
  ppp_printer i_ppp_printer (.mclk(mclk), .pins_o(pins_o),
    .paper_out(paper_out), .online(online), .pins_i(pins_i), .got(got));

  // length of the last restart low pulse
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (pins_o.init_n === 1'b0) lowrun <= lowrun + 1;
    else if (lowrun != 0) begin
      lastrun <= lowrun;
      lowrun <= 0;
    end
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: %s got %h", $time, m, g);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    err = pslverr;
    if (n >= 50) chk(32'h1, 32'h0, "no ready");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // let registered outputs follow a finished write
  task automatic settle();
    @(posedge mclk);
    @(negedge mclk);
  endtask : settle

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, e, "read data");
  endtask : rd

  // byte-taken pulse seen low then high, then sync settles
  task automatic wait_ack();
    int n;
    n = 0;
    while (pins_i.ack_n !== 1'b0 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    while (pins_i.ack_n !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 3000) chk(32'h1, 32'h0, "no byte-taken pulse");
    repeat (6) @(posedge mclk);
  endtask : wait_ack

  initial begin
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({20'h0, pins_o}, {20'h0, 8'h00, 4'hF}, "reset pins");
    chk({31'h0, irq7}, 32'h0, "reset irq7");
    rd(ADR_CTRL, 32'h04);
    wr(ADR_DATA, 32'hA5);
    rd(ADR_DATA, 32'hA5);
    chk({24'h0, pins_o.data}, 32'hA5, "data pins");
    wr(ADR_EVEN, 32'h1);
    wr(ADR_CTRL, 32'h1F);
    settle();
    chk({28'h0, pins_o[3:0]}, 32'h2, "ctrl pins");
    rd(ADR_CTRL, 32'h1F);
    wr(ADR_CTRL, 32'h14);
    chk({24'h0, got}, 32'hA5, "byte taken");
    wait_ack();
    chk({30'h0, irq7, irq}, 32'h3, "irq raised");
    rd(ADR_STAT, 32'hDC);
    rd(ADR_STAT, 32'hD8);
    chk({31'h0, irq7}, 32'h0, "irq7 cleared");
    wr(ADR_EVEN, 32'h0);
    settle();
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(ADR_EVEN, 32'hF);
    settle();
    chk({31'h0, irq}, 32'h1, "irq unmasked");
    rd(ADR_EVST, 32'h3);
    wr(ADR_EVCLR, 32'hF);
    rd(ADR_EVST, 32'h0);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    wr(ADR_CTRL, 32'h05);
    wr(ADR_CTRL, 32'h04);
    wait_ack();
    chk({31'h0, irq7}, 32'h0, "irq7 gated");
    rd(ADR_STAT, 32'hD8);
    paper_out <= 1'b1;
    online <= 1'b0;
    repeat (5) @(posedge mclk);
    rd(ADR_STAT, 32'h60);
    rd(ADR_EVST, 32'hF);
    rd(12'h000, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    wr(ADR_CTRL, 32'h00);
    settle();
    chk({31'h0, pins_o.init_n}, 32'h0, "restart low");
    wr(ADR_CTRL, 32'h04);
    repeat (INIT + 10) @(posedge mclk);
    chk({31'h0, pins_o.init_n}, 32'h1, "restart high");
    chk({31'h0, lastrun > INIT}, 32'h1, "restart width");
    stop_test();
  end
endmodule : tb_ppp_port
